//--- logic/prr_pin_edge.v
// registered copy of a sampled pin with rise and fall detection
`timescale 1ns/100ps

module prr_pin_edge
#(
  parameter        W          = 1,
  parameter [W-1:0] IDLE_LEVEL = {W{1'b1}}
)
(
  input  wire         mclk_in,
  input  wire         sys_rst_in,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] level_out,
  output wire [W-1:0] rise_out,
  output wire [W-1:0] fall_out
);

  reg [W-1:0] last;

  // idle bus level at reset so release causes no false edge
  always @(posedge mclk_in)
  begin
    if (sys_rst_in)
      last <= IDLE_LEVEL;
    else
      last <= pin_in;
  end

  assign level_out = last;
  assign rise_out  = pin_in & ~last;
  assign fall_out  = ~pin_in & last;

endmodule // prr_pin_edge

//--- logic/prr_readout_map.vh
// register map, field positions and reset values of the pressure result readout
`ifndef PRR_READOUT_MAP_VH
`define PRR_READOUT_MAP_VH

// register pointer values, one 32-bit word each
`define PRR_REG_STATUS         8'h00
`define PRR_REG_PRESSURE       8'h01
`define PRR_REG_TEMPERATURE    8'h02
`define PRR_REG_RAW_PRESSURE   8'h03
`define PRR_REG_PRESSURE_MV    8'h06
`define PRR_REG_UNIT_SELECT    8'h54

// status register fields
`define PRR_DONE_FLAG_BIT      0

// reset values
`define PRR_RESULT_RESET       32'h00000000
`define PRR_UNIT_RESET         32'h00000000
`define PRR_STATUS_RESET       1'b0

// two-wire transfer framing
`define PRR_BITS_PER_BYTE      4'h8
`define PRR_LAST_BIT           4'h7
`define PRR_LAST_BYTE_OF_WORD  2'h3

`endif

//--- logic/prr_result_readout.v
// result and status registers of the pressure transducer behind a two-wire slave
`timescale 1ns/100ps
`include "prr_readout_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - pointer 1 reads the latest compensated pressure as a 32-bit float, read only.
// - that pressure is in the unit held by the unit select register at pointer 84.
// - reading compensated pressure in automatic update mode clears the done flag.
// - pointer 2 reads the latest compensated temperature as a 32-bit float, read only.
// - reading compensated temperature in automatic update mode clears the done flag.
// - pointer 3 reads the latest raw pressure converter count, read only.
// - the millivolt value at pointer 6 is derived from the current raw count.
// - reading the raw count in automatic update mode clears the done flag.
// - the raw count is an unsigned 32-bit integer, passed through unconverted.
// - host writes 1 to the done flag to request an update, 0 to clear; updates set it.
////////////////////////////////////////////////////////////////////////////////

module prr_result_readout
#(
  parameter [6:0] DEV_ADDR = 7'h28  // arbitrary bus address
)
(
  input  wire        mclk_in,
  input  wire        sys_rst_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_out,
  input  wire        auto_update_mode_in,
  input  wire        results_update_in,
  input  wire [31:0] compensated_pressure_in,
  input  wire [31:0] compensated_temperature_in,
  input  wire [31:0] raw_pressure_count_in,
  input  wire [31:0] pressure_millivolt_in,
  output wire        update_request_out,
  output wire [31:0] pressure_unit_select_out,
  output wire [31:0] raw_pressure_count_out,
  output wire        conversion_done_flag_out
);

  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_RXB  = 5'b00010;
  localparam [4:0] S_ACK  = 5'b00100;
  localparam [4:0] S_TXB  = 5'b01000;
  localparam [4:0] S_RACK = 5'b10000;

  localparam [1:0] IDX_ADDR = 2'h0;
  localparam [1:0] IDX_PTR  = 2'h1;
  localparam [1:0] IDX_DATA = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // pin sampling: clock in bit 1, data in bit 0, both idle high
  wire [1:0] pin_level;
  wire [1:0] pin_rise;
  wire [1:0] pin_fall;
  prr_pin_edge #(.W(2), .IDLE_LEVEL(2'b11)) prr_pin_edge_i
  (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .pin_in({scl_in, sda_in}),
   .level_out(pin_level), .rise_out(pin_rise), .fall_out(pin_fall));
  wire scl       = pin_level[1];
  wire sda       = pin_level[0];
  wire scl_rise  = pin_rise[1];
  wire scl_fall  = pin_fall[1];
  wire sda_rise  = pin_rise[0];
  wire sda_fall  = pin_fall[0];
  wire start_det = scl & sda_fall;
  wire stop_det  = scl & sda_rise;

  //////////////////////////////////////////////////////////////////////////////
  // state

  reg [4:0]  state;
  reg [3:0]  bit_cnt;
  reg [7:0]  rx_byte;
  reg [1:0]  byte_idx;
  reg        rw;
  reg        last_was_addr;
  reg [7:0]  reg_ptr;
  reg [31:0] wr_word;
  reg [1:0]  wr_cnt;
  reg [31:0] tx_word;
  reg [1:0]  tx_cnt;
  reg        ack_ok;
  reg [31:0] compensated_pressure_value;
  reg [31:0] compensated_temperature_value;
  reg [31:0] raw_pressure_converter_count;
  reg [31:0] unit_select;
  reg        done_flag;
  reg        update_req;

  //////////////////////////////////////////////////////////////////////////////
  // transfer events

  wire       byte_done  = (state == S_RXB) & scl_fall & (bit_cnt == `PRR_BITS_PER_BYTE);
  wire       load_first = (state == S_ACK) & scl_fall & rw & last_was_addr;
  wire       load_next  = (state == S_RACK) & scl_fall & ack_ok &
                          (tx_cnt == `PRR_LAST_BYTE_OF_WORD);
  wire       word_load  = load_first | load_next;
  wire [7:0] load_ptr   = load_next ? reg_ptr + 8'h01 : reg_ptr;

  wire        wr_commit = byte_done & (byte_idx == IDX_DATA) &
                          (wr_cnt == `PRR_LAST_BYTE_OF_WORD);
  wire [31:0] wr_value  = {wr_word[23:0], rx_byte};

  // in automatic update mode, a word fetched from a result register counts as a read of it
  wire result_read = word_load & auto_update_mode_in &
                     ((load_ptr == `PRR_REG_PRESSURE) |
                      (load_ptr == `PRR_REG_TEMPERATURE) |
                      (load_ptr == `PRR_REG_RAW_PRESSURE));

  wire status_wr = wr_commit & (reg_ptr == `PRR_REG_STATUS);
  wire unit_wr   = wr_commit & (reg_ptr == `PRR_REG_UNIT_SELECT);

  //////////////////////////////////////////////////////////////////////////////
  // read data mux

  reg [31:0] rd_data;
  always @*
  begin
    case (load_ptr)
      `PRR_REG_STATUS:        rd_data = {31'h00000000, done_flag};
      `PRR_REG_PRESSURE:      rd_data = compensated_pressure_value;
      `PRR_REG_TEMPERATURE:   rd_data = compensated_temperature_value;
      `PRR_REG_RAW_PRESSURE:  rd_data = raw_pressure_converter_count;
      // taken live so it always follows the raw count now held
      `PRR_REG_PRESSURE_MV:   rd_data = pressure_millivolt_in;
      `PRR_REG_UNIT_SELECT:   rd_data = unit_select;
      default:                rd_data = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // two-wire byte engine

  always @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      state         <= S_IDLE;
      bit_cnt       <= 4'h0;
      rx_byte       <= 8'h00;
      byte_idx      <= IDX_ADDR;
      rw            <= 1'b0;
      last_was_addr <= 1'b0;
      reg_ptr       <= 8'h00;
      wr_word       <= 32'h00000000;
      wr_cnt        <= 2'h0;
      tx_word       <= 32'h00000000;
      tx_cnt        <= 2'h0;
      ack_ok        <= 1'b0;
    end
    else if (start_det)
    begin
      // repeated start keeps the pointer so a read can follow a pointer write
      state    <= S_RXB;
      bit_cnt  <= 4'h0;
      byte_idx <= IDX_ADDR;
      wr_cnt   <= 2'h0;
    end
    else if (stop_det)
      state <= S_IDLE;
    else
    begin
      case (state)
        S_RXB:
          if (scl_rise && bit_cnt != `PRR_BITS_PER_BYTE)
          begin
            rx_byte <= {rx_byte[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (byte_done)
          begin
            bit_cnt       <= 4'h0;
            last_was_addr <= (byte_idx == IDX_ADDR);
            case (byte_idx)
              IDX_ADDR:
                if (rx_byte[7:1] == DEV_ADDR)
                begin
                  rw       <= rx_byte[0];
                  byte_idx <= IDX_PTR;
                  state    <= S_ACK;
                end
                else
                  state <= S_IDLE;
              IDX_PTR:
              begin
                reg_ptr  <= rx_byte;
                byte_idx <= IDX_DATA;
                state    <= S_ACK;
              end
              default:
              begin
                wr_word <= wr_value;
                wr_cnt  <= wr_cnt + 2'h1;
                state   <= S_ACK;
                if (wr_commit)
                  reg_ptr <= reg_ptr + 8'h01;
              end
            endcase
          end
        S_ACK:
          if (scl_fall)
          begin
            if (load_first)
            begin
              tx_word <= rd_data;
              tx_cnt  <= 2'h0;
              state   <= S_TXB;
            end
            else
              state <= S_RXB;
          end
        S_TXB:
          if (scl_fall)
          begin
            tx_word <= {tx_word[30:0], 1'b0};
            if (bit_cnt == `PRR_LAST_BIT)
            begin
              bit_cnt <= 4'h0;
              state   <= S_RACK;
            end
            else
              bit_cnt <= bit_cnt + 4'h1;
          end
        S_RACK:
          if (scl_rise)
            ack_ok <= ~sda;
          else if (scl_fall)
          begin
            if (ack_ok)
            begin
              tx_cnt <= tx_cnt + 2'h1;
              state  <= S_TXB;
              if (load_next)
              begin
                tx_word <= rd_data;
                reg_ptr <= load_ptr;
              end
            end
            else
              state <= S_IDLE;
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // open drain: only ever pull low
  assign sda_out    = 1'b0;
  assign sda_oe_out = (state == S_ACK) | ((state == S_TXB) & ~tx_word[31]);

  //////////////////////////////////////////////////////////////////////////////
  // result registers, unit select and done flag

  always @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      compensated_pressure_value    <= `PRR_RESULT_RESET;
      compensated_temperature_value <= `PRR_RESULT_RESET;
      raw_pressure_converter_count  <= `PRR_RESULT_RESET;
      unit_select                   <= `PRR_UNIT_RESET;
      done_flag                     <= `PRR_STATUS_RESET;
      update_req                    <= 1'b0;
    end
    else
    begin
      // host writes never reach the result words
      if (results_update_in)
      begin
        compensated_pressure_value    <= compensated_pressure_in;
        compensated_temperature_value <= compensated_temperature_in;
        raw_pressure_converter_count  <= raw_pressure_count_in;
      end
      if (unit_wr)
        unit_select <= wr_value;
      update_req <= status_wr & wr_value[`PRR_DONE_FLAG_BIT];
      // an update in the same cycle as a clear wins
      if (results_update_in)
        done_flag <= 1'b1;
      else if (result_read)
        done_flag <= 1'b0;
      else if (status_wr && !wr_value[`PRR_DONE_FLAG_BIT])
        done_flag <= 1'b0;
    end
  end

  assign update_request_out       = update_req;
  assign pressure_unit_select_out = unit_select;
  // the millivolt converter works from the held raw count
  assign raw_pressure_count_out   = raw_pressure_converter_count;
  assign conversion_done_flag_out = done_flag;

endmodule // prr_result_readout

//--- tb/prr_host_model.sv
// two-wire bus host: clock and open-drain data
`timescale 1ns/100ps
module prr_host_model
#(
  parameter [6:0] DEV = 7'h28, // arbitrary bus address
  parameter       Q   = 4
)
(
  input  wire mclk_in,
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_low_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic wt(input integer n);
    repeat (n) @(posedge mclk_in);
  endtask
  // also a repeated start when entered with clock low
  task automatic start_c;
    begin
      wt(1);
      sda_low_out <= 1'b0;
      wt(Q);
      scl_out <= 1'b1;
      wt(Q);
      sda_low_out <= 1'b1;
      wt(Q);
      scl_out <= 1'b0;
      wt(Q);
    end
  endtask
  task automatic stop_c;
    begin
      sda_low_out <= 1'b1;
      wt(Q);
      scl_out <= 1'b1;
      wt(Q);
      sda_low_out <= 1'b0;
      wt(Q);
    end
  endtask
  // data set a full phase before the rise: the slave samples one cycle late
  task automatic xfer(input [8:0] d, output [8:0] r);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1)
      begin
        sda_low_out <= ~d[i];
        wt(Q);
        scl_out <= 1'b1;
        wt(Q);
        r[i] = sda_in;
        scl_out <= 1'b0;
        wt(Q);
      end
    end
  endtask
  task automatic wr(input [7:0] p, input [31:0] v, input [6:0] a, output ok);
    reg [8:0] r;
    integer k;
    begin
      start_c;
      xfer({a, 2'b01}, r);
      ok = ~r[0];
      xfer({p, 1'b1}, r);
      ok = ok & ~r[0];
      for (k = 3; k >= 0; k = k - 1)
      begin
        xfer({v[k*8 +: 8], 1'b1}, r);
        ok = ok & ~r[0];
      end
      stop_c;
    end
  endtask
  task automatic rd(input [7:0] p, output [31:0] v, output ok);
    reg [8:0] r;
    integer k;
    begin
      start_c;
      xfer({DEV, 2'b01}, r);
      ok = ~r[0];
      xfer({p, 1'b1}, r);
      ok = ok & ~r[0];
      start_c;
      xfer({DEV, 2'b11}, r);
      ok = ok & ~r[0];
      for (k = 3; k >= 0; k = k - 1)
      begin
        xfer({8'hFF, k == 0}, r);
        v[k*8 +: 8] = r[8:1];
      end
      stop_c;
    end
  endtask
endmodule // prr_host_model

//--- tb/prr_props.sv
// port relation checker for the pressure result readout
`timescale 1ns/100ps
module prr_props
(
  input wire        mclk_in,
  input wire        sys_rst_in,
  input wire        scl_in,
  input wire        sda_out,
  input wire        sda_oe_out,
  input wire        results_update_in,
  input wire [31:0] raw_pressure_count_in,
  input wire [31:0] raw_pressure_count_out,
  input wire        update_request_out,
  input wire        conversion_done_flag_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  property p_upd_flag; results_update_in |=> conversion_done_flag_out; endproperty
  a_upd_flag: assert property (p_upd_flag) else $error("flag not set");
  property p_flag_rise; $rose(conversion_done_flag_out) |-> $past(results_update_in); endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set unprompted");
  property p_flag_fall;
    $fell(conversion_done_flag_out) |-> !scl_in && !$past(results_update_in);
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag cleared off a fetch");
  property p_raw_load;
    results_update_in |=> raw_pressure_count_out == $past(raw_pressure_count_in);
  endproperty
  a_raw_load: assert property (p_raw_load) else $error("raw count not latched");
  property p_raw_hold; !results_update_in |=> $stable(raw_pressure_count_out); endproperty
  a_raw_hold: assert property (p_raw_hold) else $error("raw count moved");
  property p_oe_move; $changed(sda_oe_out) |-> !scl_in; endproperty
  a_oe_move: assert property (p_oe_move) else $error("data moved with clock high");
  property p_open_drain; sda_oe_out |-> !sda_out; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data drives high");
  property p_req_pulse; update_request_out |=> !update_request_out; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request too long");
  property p_req_low; update_request_out |-> !scl_in && !$past(scl_in); endproperty
  a_req_low: assert property (p_req_low) else $error("request off commit");
endmodule // prr_props

//--- tb/tb_top.sv
// bench for the pressure result readout over the two-wire bus
`timescale 1ns/100ps
`include "prr_readout_map.vh"
module tb_top;
  reg         clk;
  reg         rst;
  reg         auto;
  reg         upd;
  reg  [31:0] cp, ct, rc, v;
  reg  [7:0]  p;
  reg         ok;
  wire [31:0] unit_sel, raw_out, mv;
  wire        scl, sda_low, sda_o, sda_oe, req, flag, sda;
  integer     failures, cmp_count;
  integer     reqs = 0;
  assign sda = ~(sda_low | (sda_oe & ~sda_o)); // pull-up when nobody pulls
  assign mv  = raw_out + 32'h10;               // stand-in conversion
  prr_result_readout prr_result_readout_i (.mclk_in(clk), .sys_rst_in(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .auto_update_mode_in(auto),
    .results_update_in(upd), .compensated_pressure_in(cp), .compensated_temperature_in(ct),
    .raw_pressure_count_in(rc), .pressure_millivolt_in(mv), .update_request_out(req),
    .pressure_unit_select_out(unit_sel), .raw_pressure_count_out(raw_out),
    .conversion_done_flag_out(flag));
  prr_host_model prr_host_model_i (.mclk_in(clk), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low));
  always @(posedge clk) if (req === 1'b1) reqs <= reqs + 1;
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task load(input [7:0] s);
    begin
      @(posedge clk);
      cp <= 32'h41200000 + s;
      ct <= 32'h41C80000 + s;
      rc <= 32'hFFFFFF00 + s;
      upd <= 1'b1;
      @(posedge clk);
      upd <= 1'b0;
      @(posedge clk);
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    failures = 0;
    cmp_count = 0;
    {auto, upd, cp, ct, rc, rst} = {2'b10, 96'h0, 1'b1};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(flag), 32'h0);
    for (p = 8'h01; p <= 8'h03; p = p + 8'h01)
    begin
      load(p);
      chk(32'(flag), 32'h1);
      chk(raw_out, 32'hFFFFFF00 + p);
      prr_host_model_i.rd(p, v, ok);
      chk(32'(ok), 32'h1);
      chk(v, p == 1 ? cp : p == 2 ? ct : rc);
      chk(32'(flag), 32'h0);
    end
    @(posedge clk);
    auto <= 1'b0;
    load(8'h07);
    prr_host_model_i.rd(`PRR_REG_TEMPERATURE, v, ok);
    chk(32'(flag), 32'h1);
    prr_host_model_i.rd(`PRR_REG_PRESSURE_MV, v, ok);
    chk(v, 32'hFFFFFF17);
    for (p = 8'h01; p <= 8'h03; p = p + 8'h01)
      prr_host_model_i.wr(p, 32'h12345678, 7'h28, ok);
    chk(raw_out, 32'hFFFFFF07);
    chk(32'(flag), 32'h1);
    prr_host_model_i.rd(`PRR_REG_PRESSURE, v, ok);
    chk(v, 32'h41200007);
    prr_host_model_i.wr(`PRR_REG_STATUS, 32'h1, 7'h28, ok);
    chk(reqs, 1);
    chk(32'(flag), 32'h1);
    prr_host_model_i.wr(`PRR_REG_STATUS, 32'h0, 7'h28, ok);
    chk(32'(flag), 32'h0);
    prr_host_model_i.wr(`PRR_REG_UNIT_SELECT, 32'h3, 7'h28, ok);
    chk(32'(ok), 32'h1);
    chk(unit_sel, 32'h3);
    prr_host_model_i.rd(`PRR_REG_UNIT_SELECT, v, ok);
    chk(v, 32'h3);
    prr_host_model_i.wr(`PRR_REG_UNIT_SELECT, 32'h5, 7'h29, ok);
    chk(32'(ok), 32'h0);
    chk(unit_sel, 32'h3);
    summarize;
  end
  initial
  begin
    #400000;
    failures = failures + 1;
    summarize;
  end
endmodule // tb_top
bind prr_result_readout prr_props prr_props_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .results_update_in(results_update_in), .raw_pressure_count_in(raw_pressure_count_in),
  .raw_pressure_count_out(raw_pressure_count_out), .update_request_out(update_request_out),
  .conversion_done_flag_out(conversion_done_flag_out));
